/* hdl/gpio_ports_c_d_e_regs.sv */
`timescale 1ns/1ps
`default_nettype none
module gpio_ports_c_d_e_regs
(
   input  wire logic        clk_sys_i,
   input  wire logic        rst_n_i,
   input  wire logic [7:0]  ds_addr_i,
   input  wire logic        ds_wr_i,
   input  wire logic        ds_rd_i,
   input  wire logic [7:0]  ds_wdata_i,
   input  wire logic [5:0]  io_addr_i,
   input  wire logic        io_wr_i,
   input  wire logic        io_rd_i,
   input  wire logic [7:0]  io_wdata_i,
   output logic      [7:0]  rdata_o,
   input  wire logic        vport_sel_e_i,
   input  wire logic        vport_dir_wr_i,
   input  wire logic [7:0]  vport_dir_wdata_i,
   output logic      [7:0]  vport_dir_rdata_o,
   input  wire logic        pull_up_disable_i,
   input  wire logic [6:0]  port_c_pin_i,
   input  wire logic [7:0]  port_d_pin_i,
   output logic      [7:0]  port_d_out_o,
   output logic      [7:0]  port_d_oe_n_o,
   output logic      [7:0]  port_d_pull_up_o,
   input  wire logic [3:0]  port_e_pin_i,
   output logic      [3:0]  port_e_out_o,
   output logic      [3:0]  port_e_oe_n_o,
   output logic      [3:0]  port_e_pull_up_o
);
   import gpio_cde_pkg::*;

   // ****************************************************************
   // Pin synchronisers
   // ****************************************************************
   logic [6:0] port_c_pin_level_bit;
   logic [7:0] port_d_pin_level_bit;
   logic [3:0] port_e_pin_level_bits;

   pin_sync #(.WIDTH(PORT_C_WIDTH)) u_sync_c
   (
      .clk_sys_i (clk_sys_i),
      .rst_n_i   (rst_n_i),
      .pin_i     (port_c_pin_i),
      .sync_o    (port_c_pin_level_bit)
   );

   pin_sync #(.WIDTH(PORT_D_WIDTH)) u_sync_d
   (
      .clk_sys_i (clk_sys_i),
      .rst_n_i   (rst_n_i),
      .pin_i     (port_d_pin_i),
      .sync_o    (port_d_pin_level_bit)
   );

   pin_sync #(.WIDTH(PORT_E_WIDTH)) u_sync_e
   (
      .clk_sys_i (clk_sys_i),
      .rst_n_i   (rst_n_i),
      .pin_i     (port_e_pin_i),
      .sync_o    (port_e_pin_level_bits)
   );

   // ****************************************************************
   // Access merging
   // ****************************************************************
   // A data-space access owns the cycle; a port-mapped access in the
   // same cycle is dropped, since the core never issues both at once.
   logic       ds_act;
   logic       acc_wr;
   logic       acc_rd;
   logic [7:0] acc_addr;
   logic [7:0] acc_wdata;
   reg_sel_e   acc_sel;

   assign ds_act    = ds_wr_i | ds_rd_i;
   assign acc_wr    = ds_act ? ds_wr_i : io_wr_i;
   assign acc_rd    = ds_act ? ds_rd_i : io_rd_i;
   // The 6-bit port-mapped address cannot reach 0x60 and above.
   assign acc_addr  = ds_act ? ds_addr_i : io_to_data(io_addr_i);
   assign acc_wdata = ds_act ? ds_wdata_i : io_wdata_i;
   assign acc_sel   = decode_offset(acc_addr);

   // ****************************************************************
   // Register file
   // ****************************************************************
   logic [7:0] ddr_d_q;
   logic [7:0] ddr_d_d;
   logic [7:0] port_d_q;
   logic [7:0] port_d_d;
   logic [3:0] ddr_e_q;
   logic [3:0] ddr_e_d;
   logic [3:0] port_e_q;
   logic [3:0] port_e_d;
   logic [7:0] rdata_q;
   logic [7:0] rdata_d;

   always_comb
   begin
      ddr_d_d  = ddr_d_q;
      port_d_d = port_d_q;
      ddr_e_d  = ddr_e_q;
      port_e_d = port_e_q;
      rdata_d  = rdata_q;
      if (acc_wr)
      begin
         unique case (acc_sel)
            SEL_NONE:   ddr_d_d = ddr_d_q;
            // Port C has no output latch here, so its toggle is a no-op.
            SEL_PIN_C:  ddr_d_d = ddr_d_q;
            SEL_PIN_D:  port_d_d = port_d_q ^ acc_wdata;
            SEL_DDR_D:  ddr_d_d = acc_wdata;
            SEL_PORT_D: port_d_d = acc_wdata;
            SEL_PIN_E:  port_e_d = port_e_q ^ acc_wdata[3:0];
            SEL_DDR_E:  ddr_e_d = acc_wdata[3:0];
            SEL_PORT_E: port_e_d = acc_wdata[3:0];
         endcase
      end
      // A virtual-port write lands last, so it wins a same-cycle clash.
      if (vport_dir_wr_i)
      begin
         if (vport_sel_e_i)
         begin
            ddr_e_d = vport_dir_wdata_i[3:0];
         end
         else
         begin
            ddr_d_d = vport_dir_wdata_i;
         end
      end
      if (acc_rd)
      begin
         unique case (acc_sel)
            SEL_NONE:   rdata_d = 8'h00;
            SEL_PIN_C:  rdata_d = {1'b0, port_c_pin_level_bit};
            SEL_PIN_D:  rdata_d = port_d_pin_level_bit;
            SEL_DDR_D:  rdata_d = ddr_d_q;
            SEL_PORT_D: rdata_d = port_d_q;
            SEL_PIN_E:  rdata_d = {4'h0, port_e_pin_level_bits};
            SEL_DDR_E:  rdata_d = {4'h0, ddr_e_q};
            SEL_PORT_E: rdata_d = {4'h0, port_e_q};
         endcase
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         ddr_d_q  <= RST_DDR_D;
         port_d_q <= RST_PORT_D;
         ddr_e_q  <= RST_DDR_E;
         port_e_q <= RST_PORT_E;
         rdata_q  <= RST_RDATA;
      end
      else
      begin
         ddr_d_q  <= ddr_d_d;
         port_d_q <= port_d_d;
         ddr_e_q  <= ddr_e_d;
         port_e_q <= port_e_d;
         rdata_q  <= rdata_d;
      end
   end

   // ****************************************************************
   // Pin drivers
   // ****************************************************************
   assign rdata_o           = rdata_q;
   assign vport_dir_rdata_o = vport_sel_e_i ? {4'h0, ddr_e_q} : ddr_d_q;
   assign port_d_out_o      = port_d_q;
   assign port_e_out_o      = port_e_q;
   assign port_d_oe_n_o     = ~ddr_d_q;
   assign port_e_oe_n_o     = ~ddr_e_q;
   assign port_d_pull_up_o  = ~ddr_d_q & port_d_q & {8{~pull_up_disable_i}};
   assign port_e_pull_up_o  = ~ddr_e_q & port_e_q & {4{~pull_up_disable_i}};

   // ****************************************************************
   // Assertions
   // ****************************************************************
   ddr_d_write_a: assert property
      (@(posedge clk_sys_i) disable iff (!rst_n_i)
       (ds_wr_i && ds_addr_i == OFF_DDR_D && !vport_dir_wr_i)
       |=> (port_d_oe_n_o == ~$past(ds_wdata_i)))
      else $error("Port D direction write not applied.");

   io_alias_a: assert property
      (@(posedge clk_sys_i) disable iff (!rst_n_i)
       (!ds_wr_i && !ds_rd_i && io_wr_i && io_addr_i == 6'h0B)
       |=> (port_d_out_o == $past(io_wdata_i)))
      else $error("Port-mapped alias of port D latch failed.");

   toggle_d_a: assert property
      (@(posedge clk_sys_i) disable iff (!rst_n_i)
       (ds_wr_i && ds_addr_i == OFF_PIN_D)
       |=> (port_d_out_o == ($past(port_d_out_o) ^ $past(ds_wdata_i))))
      else $error("Port D pin write did not toggle the latch.");

   toggle_e_a: assert property
      (@(posedge clk_sys_i) disable iff (!rst_n_i)
       (ds_wr_i && ds_addr_i == OFF_PIN_E)
       |=> (port_e_out_o == ($past(port_e_out_o) ^ $past(ds_wdata_i[3:0]))))
      else $error("Port E pin write did not toggle the latch.");

   pin_read_d_a: assert property
      (@(posedge clk_sys_i) disable iff (!rst_n_i)
       (ds_rd_i && ds_addr_i == OFF_PIN_D && $past(rst_n_i, 2))
       |=> (rdata_o == $past(port_d_pin_i, 3)))
      else $error("Port D pin read not two stages behind the pins.");

   pin_c_top_a: assert property
      (@(posedge clk_sys_i) disable iff (!rst_n_i)
       (ds_rd_i && ds_addr_i == OFF_PIN_C) |=> (rdata_o[7] == 1'b0))
      else $error("Port C pin read shows bit 7 set.");

   e_upper_zero_a: assert property
      (@(posedge clk_sys_i) disable iff (!rst_n_i)
       (ds_rd_i && ds_addr_i == OFF_PORT_E)
       |=> (rdata_o == {4'h0, port_e_out_o}))
      else $error("Port E latch read wrong.");

   pull_up_off_a: assert property
      (@(posedge clk_sys_i) disable iff (!rst_n_i)
       pull_up_disable_i |-> (port_d_pull_up_o == 8'h00 && port_e_pull_up_o == 4'h0))
      else $error("Pull-up on while disabled.");

   vport_dir_a: assert property
      (@(posedge clk_sys_i) disable iff (!rst_n_i)
       (vport_dir_wr_i && vport_sel_e_i)
       |=> (port_e_oe_n_o == ~$past(vport_dir_wdata_i[3:0])))
      else $error("Virtual direction write did not reach port E.");

   unmapped_a: assert property
      (@(posedge clk_sys_i) disable iff (!rst_n_i)
       (ds_rd_i && ds_addr_i == OFF_PORT_D - IO_SPACE_BASE) |=> (rdata_o == 8'h00))
      else $error("Data-space access to the port-mapped number decoded.");

endmodule
`default_nettype wire

/* hdl/pin_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module pin_sync
#(
   parameter int unsigned WIDTH = 8
)
(
   input  wire logic             clk_sys_i,
   input  wire logic             rst_n_i,
   input  wire logic [WIDTH-1:0] pin_i,
   output logic      [WIDTH-1:0] sync_o
);
   import gpio_cde_pkg::*;

   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] meta_d;
   logic [WIDTH-1:0] stable_q;
   logic [WIDTH-1:0] stable_d;

   // The first stage feeds only the second one, so a metastable level
   // never reaches the read path.
   always_comb
   begin
      meta_d   = pin_i;
      stable_d = meta_q;
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         meta_q   <= RST_SYNC[WIDTH-1:0];
         stable_q <= RST_SYNC[WIDTH-1:0];
      end
      else
      begin
         meta_q   <= meta_d;
         stable_q <= stable_d;
      end
   end

   assign sync_o = stable_q;

endmodule
`default_nettype wire

/* inc/gpio_cde_pkg.sv */
`default_nettype none
package gpio_cde_pkg;

   // ****************************************************************
   // Address map
   // ****************************************************************
   localparam logic [7:0] IO_SPACE_BASE = 8'h20;
   localparam logic [7:0] EXT_IO_BASE   = 8'h60;
   localparam logic [7:0] OFF_PIN_C     = 8'h26;
   localparam logic [7:0] OFF_PIN_D     = 8'h29;
   localparam logic [7:0] OFF_DDR_D     = 8'h2A;
   localparam logic [7:0] OFF_PORT_D    = 8'h2B;
   localparam logic [7:0] OFF_PIN_E     = 8'h2C;
   localparam logic [7:0] OFF_DDR_E     = 8'h2D;
   localparam logic [7:0] OFF_PORT_E    = 8'h2E;

   // ****************************************************************
   // Widths and reset values
   // ****************************************************************
   localparam int unsigned PORT_C_WIDTH = 7;
   localparam int unsigned PORT_D_WIDTH = 8;
   localparam int unsigned PORT_E_WIDTH = 4;
   localparam logic [7:0]  RST_DDR_D    = 8'h00;
   localparam logic [7:0]  RST_PORT_D   = 8'h00;
   localparam logic [3:0]  RST_DDR_E    = 4'h0;
   localparam logic [3:0]  RST_PORT_E   = 4'h0;
   localparam logic [7:0]  RST_RDATA    = 8'h00;
   localparam logic [7:0]  RST_SYNC     = 8'h00;

   typedef enum logic [2:0] {
      SEL_NONE,
      SEL_PIN_C,
      SEL_PIN_D,
      SEL_DDR_D,
      SEL_PORT_D,
      SEL_PIN_E,
      SEL_DDR_E,
      SEL_PORT_E
   } reg_sel_e;

   // ****************************************************************
   // Decoding helpers
   // ****************************************************************
   function automatic reg_sel_e decode_offset(input logic [7:0] off);
      reg_sel_e sel;
      sel = SEL_NONE;
      case (off)
         OFF_PIN_C:  sel = SEL_PIN_C;
         OFF_PIN_D:  sel = SEL_PIN_D;
         OFF_DDR_D:  sel = SEL_DDR_D;
         OFF_PORT_D: sel = SEL_PORT_D;
         OFF_PIN_E:  sel = SEL_PIN_E;
         OFF_DDR_E:  sel = SEL_DDR_E;
         OFF_PORT_E: sel = SEL_PORT_E;
         default:    sel = SEL_NONE;
      endcase
      return sel;
   endfunction

   function automatic logic [7:0] io_to_data(input logic [5:0] io_addr);
      return {2'b00, io_addr} + IO_SPACE_BASE;
   endfunction

endpackage
`default_nettype wire

/* tb/gpio_pin_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Package pins of ports D and E
// ****************************************************************
module gpio_pin_model
(
   input  wire logic [7:0] d_out_i,
   input  wire logic [7:0] d_oe_n_i,
   input  wire logic [7:0] d_pu_i,
   input  wire logic [7:0] d_ext_i,
   output logic      [7:0] d_pin_o,
   input  wire logic [3:0] e_out_i,
   input  wire logic [3:0] e_oe_n_i,
   input  wire logic [3:0] e_pu_i,
   input  wire logic [3:0] e_ext_i,
   output logic      [3:0] e_pin_o
);
   // A driven pin shows its latch; an undriven one floats to the pull-up or the outside level.
   // The outside level wins over the weak pull-up only when it is high, which keeps the model simple.
   assign d_pin_o = (~d_oe_n_i & d_out_i) | (d_oe_n_i & (d_pu_i | d_ext_i));
   assign e_pin_o = (~e_oe_n_i & e_out_i) | (e_oe_n_i & (e_pu_i | e_ext_i));
endmodule
`default_nettype wire

/* tb/test_gpio_ports_c_d_e_regs.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Register-level bench
// ****************************************************************
module test_gpio_ports_c_d_e_regs;
   import gpio_cde_pkg::*;
   logic       clk_sys_i = 1'b0;
   logic       rst_n_i   = 1'b0;
   logic [7:0] ds_addr   = 8'h00;
   logic [7:0] ds_wdata  = 8'h00;
   logic [7:0] io_wdata  = 8'h00;
   logic [7:0] vd        = 8'h00;
   logic [7:0] ext_d     = 8'h00;
   logic [5:0] io_addr   = 6'h00;
   logic       ds_wr     = 1'b0;
   logic       ds_rd     = 1'b0;
   logic       io_wr     = 1'b0;
   logic       io_rd     = 1'b0;
   logic       vsel      = 1'b0;
   logic       vwr       = 1'b0;
   logic       pull_up_disable       = 1'b0;
   logic [6:0] ext_c     = 7'h00;
   logic [3:0] ext_e     = 4'h0;
   logic [7:0] rdata, vrd, d_out, d_oe_n, d_pu, d_pin;
   logic [3:0] e_out, e_oe_n, e_pu, e_pin;
   int         fails       = 0;
   int         comparisons = 0;

   always #20 clk_sys_i = ~clk_sys_i;

   gpio_ports_c_d_e_regs u_gpio_ports_c_d_e_regs (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
      .ds_addr_i(ds_addr), .ds_wr_i(ds_wr), .ds_rd_i(ds_rd), .ds_wdata_i(ds_wdata),
      .io_addr_i(io_addr), .io_wr_i(io_wr), .io_rd_i(io_rd), .io_wdata_i(io_wdata),
      .rdata_o(rdata), .vport_sel_e_i(vsel), .vport_dir_wr_i(vwr), .vport_dir_wdata_i(vd),
      .vport_dir_rdata_o(vrd), .pull_up_disable_i(pull_up_disable), .port_c_pin_i(ext_c),
      .port_d_pin_i(d_pin), .port_d_out_o(d_out), .port_d_oe_n_o(d_oe_n),
      .port_d_pull_up_o(d_pu), .port_e_pin_i(e_pin), .port_e_out_o(e_out),
      .port_e_oe_n_o(e_oe_n), .port_e_pull_up_o(e_pu));

   gpio_pin_model u_gpio_pin_model (.d_out_i(d_out), .d_oe_n_i(d_oe_n), .d_pu_i(d_pu),
      .d_ext_i(ext_d), .d_pin_o(d_pin), .e_out_i(e_out), .e_oe_n_i(e_oe_n), .e_pu_i(e_pu),
      .e_ext_i(ext_e), .e_pin_o(e_pin));

   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
      comparisons++;
      if (s !== e)
      begin
         fails++;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask

   // One access per call; the strobe is dropped at the next edge so strobes never merge.
   task automatic acc(input logic io, input logic wr, input logic [7:0] a, input logic [7:0] v,
                      input string n);
      @(posedge clk_sys_i);
      io_addr  <= 6'(a - IO_SPACE_BASE);
      ds_addr  <= a;
      io_wdata <= v;
      ds_wdata <= v;
      io_wr    <= io & wr;
      ds_wr    <= !io & wr;
      io_rd    <= io & !wr;
      ds_rd    <= !io & !wr;
      @(posedge clk_sys_i);
      {io_wr, ds_wr, io_rd, ds_rd} <= 4'h0;
      #1;
      if (!wr)
         chk(n, v, rdata);
   endtask

   task automatic t_reset;
      #1;
      chk("d_out", 8'h00, d_out);
      chk("d_oe_n", 8'hFF, d_oe_n);
      chk("e_oe_n", 8'h0F, {4'h0, e_oe_n});
      acc(1'b0, 1'b0, OFF_DDR_D, 8'h00, "ddr_d");
      acc(1'b1, 1'b0, OFF_PORT_E, 8'h00, "port_e");
      acc(1'b1, 1'b0, OFF_DDR_E, 8'h00, "ddr_e");
   endtask

   task automatic t_rw;
      acc(1'b1, 1'b1, OFF_PORT_D, 8'hA5, "");
      acc(1'b0, 1'b0, OFF_PORT_D, 8'hA5, "port_d");
      chk("d_out", 8'hA5, d_out);
      acc(1'b0, 1'b1, OFF_PORT_E, 8'hFF, "");
      acc(1'b1, 1'b0, OFF_PORT_E, 8'h0F, "port_e");
      chk("e_out", 8'h0F, {4'h0, e_out});
      acc(1'b0, 1'b1, OFF_DDR_E, 8'hFF, "");
      acc(1'b1, 1'b0, OFF_DDR_E, 8'h0F, "ddr_e");
   endtask

   task automatic t_toggle;
      acc(1'b0, 1'b1, OFF_PORT_D, 8'h5A, "");
      acc(1'b0, 1'b1, OFF_PIN_D, 8'h0F, "");
      chk("d_out", 8'h55, d_out);
      acc(1'b1, 1'b1, OFF_PIN_E, 8'hF3, "");
      chk("e_out", 8'h0C, {4'h0, e_out});
   endtask

   // Pin reads go through a two-flop synchroniser, so each level change gets an extra edge.
   task automatic t_dir;
      @(posedge clk_sys_i);
      ext_d <= 8'h33;
      acc(1'b1, 1'b1, OFF_DDR_D, 8'hF0, "");
      chk("d_oe_n", 8'h0F, d_oe_n);
      chk("d_pu", 8'h05, d_pu);
      // The direction change reaches the pins only after the write edge.
      @(posedge clk_sys_i);
      acc(1'b0, 1'b0, OFF_PIN_D, 8'h57, "pin_d");
      @(posedge clk_sys_i);
      pull_up_disable <= 1'b1;
      @(posedge clk_sys_i);
      #1;
      chk("d_pu", 8'h00, d_pu);
      acc(1'b1, 1'b0, OFF_PIN_D, 8'h53, "pin_d");
   endtask

   task automatic t_vport;
      @(posedge clk_sys_i);
      vsel <= 1'b1;
      vd   <= 8'h05;
      vwr  <= 1'b1;
      @(posedge clk_sys_i);
      vwr <= 1'b0;
      #1;
      chk("e_oe_n", 8'h0A, {4'h0, e_oe_n});
      chk("vdir_e", 8'h05, {4'h0, vrd[3:0]});
      acc(1'b0, 1'b0, OFF_DDR_E, 8'h05, "ddr_e");
      @(posedge clk_sys_i);
      vsel <= 1'b0;
      #1;
      chk("vdir_d", 8'hF0, vrd);
      @(posedge clk_sys_i);
      vd        <= 8'hC3;
      vwr       <= 1'b1;
      ds_addr   <= OFF_DDR_D;
      ds_wdata  <= 8'h0F;
      ds_wr     <= 1'b1;
      @(posedge clk_sys_i);
      vwr   <= 1'b0;
      ds_wr <= 1'b0;
      #1;
      chk("d_oe_n", 8'h3C, d_oe_n);
      acc(1'b0, 1'b1, OFF_DDR_D, 8'hF0, "");
      chk("d_oe_n", 8'h0F, d_oe_n);
   endtask

   task automatic t_misc;
      @(posedge clk_sys_i);
      ext_c <= 7'h55;
      ext_e <= 4'hF;
      pull_up_disable   <= 1'b0;
      @(posedge clk_sys_i);
      #1;
      chk("e_pu", 8'h08, {4'h0, e_pu});
      acc(1'b1, 1'b0, OFF_PIN_C, 8'h55, "pin_c");
      acc(1'b0, 1'b0, OFF_PIN_C, 8'h55, "pin_c");
      acc(1'b0, 1'b0, OFF_PIN_E, 8'h0E, "pin_e");
      acc(1'b0, 1'b0, OFF_PORT_E, 8'h0C, "port_e");
      acc(1'b0, 1'b1, EXT_IO_BASE, 8'hFF, "");
      acc(1'b0, 1'b0, EXT_IO_BASE, 8'h00, "ext_io");
      acc(1'b0, 1'b0, OFF_PORT_D - IO_SPACE_BASE, 8'h00, "unmapped");
      acc(1'b1, 1'b1, OFF_PIN_C, 8'hFF, "");
      chk("d_out", 8'h55, d_out);
      acc(1'b0, 1'b1, OFF_PIN_E, 8'h0F, "");
      chk("e_out", 8'h03, {4'h0, e_out});
   endtask

   task automatic test_done;
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   initial
   begin
      repeat (8) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      t_reset();
      t_rw();
      t_toggle();
      t_dir();
      t_vport();
      t_misc();
      test_done();
   end

   // The whole sequence needs about seventy cycles; this limit leaves wide room.
   initial
   begin
      #50000;
      fails++;
      test_done();
   end
endmodule
`default_nettype wire
